// file: hw/phy_link_status_receive.sv
// link side decoder of phy status transfers and received packets
`timescale 1ns/1ps
// Function
// - bits 4-7 give the returned register address, bits 8-15 its contents
// - bit 0 feeds busy/retry logic; bit 1 marks isochronous cycle completion
// - bit 2 means bus-reset start; bit 3 means a phy interrupt event
// - flags count once sent; register counts only after all eight cycles (sixteen bits)
// - speed 00xx=base, 0100=double, 01010000=quad; top bit set is data-on
// - speed taken on first non-data-on receive cycle; later cycles are data
// - data after an invalid or unsupported speed code is discarded
// - speed code cycle is kept out of the packet byte stream and fifo
// - receive code is binary 10; pending fair or priority requests are lost
// - idle code is binary 00
module phy_link_status_receive (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // phy interface lines, from the phy pins
  input wire logic [1:0] interface_control_lines,
  input wire logic [7:0] phy_data,
  // highest rate this link handles
  input wire logic [1:0] max_rate,
  // status flag pulses
  output logic arb_reset_gap,
  output logic subaction_gap,
  output logic bus_reset_start,
  output logic phy_interrupt,
  // returned register
  output logic reg_valid,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_data,
  // receive framing
  output logic rx_active,
  output logic rx_speed_valid,
  output logic [1:0] rx_speed,
  output logic rx_null_packet,
  output logic rx_packet_end,
  output logic rx_overflow,
  output logic fair_request_lost,
  // packet byte stream, speed code never included
  output logic pkt_valid,
  input wire logic pkt_ready,
  output logic [7:0] pkt_data
);
  typedef struct packed {
    logic [1:0] ctl_s1;
    logic [1:0] ctl_s2;
    logic [1:0] ctl_s3;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [7:0] d_s3;
    phy_rx_pkg::link_state_t state;
    logic [2:0] stat_cnt;
    logic [15:0] stat_bits;
    logic [3:0] flags;
    logic reg_valid;
    logic [3:0] reg_addr;
    logic [7:0] reg_data;
    logic rx_active;
    logic speed_valid;
    logic [1:0] speed;
    logic discard;
    logic null_pkt;
    logic pkt_end;
    logic overflow;
    logic req_lost;
    logic byte_valid;
    logic [7:0] byte_data;
  } link_t;

  link_t s_reg;
  link_t s_next;
  logic [1:0] ctl;
  logic [7:0] dat;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // decode a speed code into a rate, or bad
  function automatic logic [1:0] decode_speed(input logic [7:0] code);
    if (code[7:6] == phy_rx_pkg::SPD_S100_TOP) begin
      decode_speed = phy_rx_pkg::RATE_S100;
    end else if (code[7:4] == phy_rx_pkg::SPD_S200_TOP) begin
      decode_speed = phy_rx_pkg::RATE_S200;
    end else if (code == phy_rx_pkg::SPD_S400_CODE) begin
      decode_speed = phy_rx_pkg::RATE_S400;
    end else begin
      decode_speed = phy_rx_pkg::RATE_BAD;
    end
  endfunction

  // synchronised lines, always taken from the third stage whether or not the second agrees
  always_comb begin
    ctl = (s_reg.ctl_s2 == s_reg.ctl_s3) ? s_reg.ctl_s2 : s_reg.ctl_s3;
    dat = (s_reg.d_s2 == s_reg.d_s3) ? s_reg.d_s2 : s_reg.d_s3;
  end

  // protocol decoder
  always_comb begin
    s_next = s_reg;
    s_next.ctl_s1 = interface_control_lines;
    s_next.ctl_s2 = s_reg.ctl_s1;
    s_next.ctl_s3 = s_reg.ctl_s2;
    s_next.d_s1 = phy_data;
    s_next.d_s2 = s_reg.d_s1;
    s_next.d_s3 = s_reg.d_s2;
    s_next.flags = 4'h0;
    s_next.reg_valid = 1'b0;
    s_next.speed_valid = 1'b0;
    s_next.null_pkt = 1'b0;
    s_next.pkt_end = 1'b0;
    // the byte offered at this edge is lost when the fifo is full, so flag it now
    s_next.overflow = s_reg.byte_valid && !fifo_in_ready;
    s_next.req_lost = 1'b0;
    s_next.byte_valid = 1'b0;
    // a partial register transfer is simply abandoned on any non-status code
    unique case (s_reg.state)
      phy_rx_pkg::ST_IDLE,
      phy_rx_pkg::ST_STATUS: begin
        if (ctl == phy_rx_pkg::CTL_STATUS) begin
          s_next.state = phy_rx_pkg::ST_STATUS;
          s_next.stat_bits[{s_reg.stat_cnt, 1'b0}] = dat[0];
          s_next.stat_bits[{s_reg.stat_cnt, 1'b1}] = dat[1];
          if (s_reg.stat_cnt == 3'h0) begin
            s_next.flags[1:0] = dat[1:0];
          end else if (s_reg.stat_cnt == 3'h1) begin
            s_next.flags[3:2] = dat[1:0];
          end
          if (s_reg.stat_cnt == phy_rx_pkg::STAT_LAST_CYCLE) begin
            s_next.reg_valid = 1'b1;
            s_next.reg_addr = s_reg.stat_bits[phy_rx_pkg::ADDR_LSB +: 4];
            s_next.reg_data = {dat[1:0], s_reg.stat_bits[13:8]};
            s_next.stat_cnt = phy_rx_pkg::STAT_CNT_RESET;
          end else begin
            s_next.stat_cnt = s_reg.stat_cnt + 3'h1;
          end
        end else begin
          s_next.stat_cnt = phy_rx_pkg::STAT_CNT_RESET;
          s_next.state = phy_rx_pkg::ST_IDLE;
          if (ctl == phy_rx_pkg::CTL_RECEIVE) begin
            s_next.state = phy_rx_pkg::ST_DATA_ON;
            s_next.rx_active = 1'b1;
            s_next.req_lost = 1'b1;
          end
        end
      end
      phy_rx_pkg::ST_DATA_ON: begin
        if (ctl != phy_rx_pkg::CTL_RECEIVE) begin
          s_next.state = phy_rx_pkg::ST_IDLE;
          s_next.rx_active = 1'b0;
          s_next.null_pkt = 1'b1;
          s_next.pkt_end = 1'b1;
        end else if (!dat[7]) begin
          s_next.state = phy_rx_pkg::ST_PACKET;
          s_next.speed = decode_speed(dat);
          s_next.speed_valid = 1'b1;
          s_next.discard = (decode_speed(dat) == phy_rx_pkg::RATE_BAD) ||
                           (decode_speed(dat) > max_rate);
        end
      end
      phy_rx_pkg::ST_PACKET: begin
        if (ctl != phy_rx_pkg::CTL_RECEIVE) begin
          s_next.state = phy_rx_pkg::ST_IDLE;
          s_next.rx_active = 1'b0;
          s_next.pkt_end = 1'b1;
          s_next.discard = 1'b0;
        end else if (!s_reg.discard) begin
          s_next.byte_valid = 1'b1;
          s_next.byte_data = dat;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.state <= phy_rx_pkg::ST_IDLE;
      s_reg.stat_bits <= phy_rx_pkg::STAT_RESET;
      s_reg.reg_addr <= phy_rx_pkg::REG_ADDR_RESET;
      s_reg.reg_data <= phy_rx_pkg::REG_DATA_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // packet byte buffer, sheds bytes when the drain stalls and it is full
  rx_fifo #(
    .WIDTH(phy_rx_pkg::FIFO_WIDTH),
    .DEPTH(phy_rx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(s_reg.byte_valid),
    .in_ready(fifo_in_ready),
    .in_data(s_reg.byte_data),
    .out_valid(fifo_out_valid),
    .out_ready(pkt_ready),
    .out_data(fifo_out_data)
  );

  // outputs from flip-flops, except pkt_valid and pkt_data, which come through fifo logic
  assign arb_reset_gap = s_reg.flags[0];
  assign subaction_gap = s_reg.flags[1];
  assign bus_reset_start = s_reg.flags[2];
  assign phy_interrupt = s_reg.flags[3];
  assign reg_valid = s_reg.reg_valid;
  assign reg_addr = s_reg.reg_addr;
  assign reg_data = s_reg.reg_data;
  assign rx_active = s_reg.rx_active;
  assign rx_speed_valid = s_reg.speed_valid;
  assign rx_speed = s_reg.speed;
  assign rx_null_packet = s_reg.null_pkt;
  assign rx_packet_end = s_reg.pkt_end;
  assign rx_overflow = s_reg.overflow;
  assign fair_request_lost = s_reg.req_lost;
  assign pkt_valid = fifo_out_valid;
  assign pkt_data = fifo_out_data;
endmodule

// file: hw/phy_rx_pkg.sv
// shared constants and types for the phy status and receive decoder
package phy_rx_pkg;
  // control line codes
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  // data line patterns and speed codes
  localparam logic [7:0] DATA_ON_CODE = 8'hFF;
  localparam logic [1:0] SPD_S100_TOP = 2'h0;
  localparam logic [3:0] SPD_S200_TOP = 4'h4;
  localparam logic [7:0] SPD_S400_CODE = 8'h50;
  localparam logic [1:0] RATE_S100 = 2'h0;
  localparam logic [1:0] RATE_S200 = 2'h1;
  localparam logic [1:0] RATE_S400 = 2'h2;
  localparam logic [1:0] RATE_BAD = 2'h3;
  // status transfer shape
  localparam logic [2:0] STAT_FLAG_CYCLES = 3'h2;
  localparam logic [2:0] STAT_LAST_CYCLE = 3'h7;
  localparam int STAT_BITS = 16;
  localparam int ADDR_LSB = 4;
  localparam int DATA_LSB = 8;
  // fifo shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // values after reset
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [3:0] REG_ADDR_RESET = 4'h0;
  localparam logic [7:0] REG_DATA_RESET = 8'h00;
  localparam logic [2:0] STAT_CNT_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STATUS = 2'b01,
    ST_DATA_ON = 2'b11,
    ST_PACKET = 2'b10
  } link_state_t;
endpackage

// file: hw/rx_fifo.sv
// synchronous valid/ready fifo for received packet bytes
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] count;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // handshakes on both sides
  assign in_ready = st_reg.count != DEPTH[AW:0];
  assign out_valid = st_reg.count != '0;
  assign out_data = mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end
endmodule

// file: testbench/phy_rx_chk.sv
// concurrent checks on the ports of the phy status and receive decoder
`timescale 1ns/1ps
module phy_rx_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // phy lines
  input wire logic [1:0] interface_control_lines,
  input wire logic [7:0] phy_data,
  // status outputs
  input wire logic arb_reset_gap,
  input wire logic subaction_gap,
  input wire logic bus_reset_start,
  input wire logic phy_interrupt,
  input wire logic reg_valid,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_data,
  // receive outputs
  input wire logic rx_active,
  input wire logic rx_speed_valid,
  input wire logic [1:0] rx_speed,
  input wire logic rx_null_packet,
  input wire logic rx_packet_end,
  input wire logic fair_request_lost
);
  logic st, rc, id, d7, s0, s1, s7;
  logic [1:0] d10;
  logic [2:0] pos_reg;
  logic [11:0] sh_reg;
  // pin codes and position inside a status transfer
  assign st = interface_control_lines == phy_rx_pkg::CTL_STATUS;
  assign rc = interface_control_lines == phy_rx_pkg::CTL_RECEIVE;
  assign id = interface_control_lines == phy_rx_pkg::CTL_IDLE;
  assign d7 = phy_data[7];
  assign d10 = phy_data[1:0];
  assign s0 = st && pos_reg == 3'h0;
  assign s1 = st && pos_reg == 3'h1;
  assign s7 = st && pos_reg == 3'h7;
  // status cycle count and the last six bit pairs
  always_ff @(posedge clk) begin
    pos_reg <= st ? pos_reg + 3'h1 : 3'h0;
    sh_reg <= {phy_data[1:0], sh_reg[11:2]};
  end
  // expected rate of a speed code
  function automatic logic [1:0] rate_of(input logic [7:0] d);
    if (d[7:6] == 2'h0) return phy_rx_pkg::RATE_S100;
    if (d[7:4] == 4'h4) return phy_rx_pkg::RATE_S200;
    if (d == 8'h50) return phy_rx_pkg::RATE_S400;
    return phy_rx_pkg::RATE_BAD;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_first_flags: assert property (
    $past(s0, 4) |-> {subaction_gap, arb_reset_gap} == $past(d10, 4))
    else $error("first flag pair wrong");
  a_second_flags: assert property (
    $past(s1, 4) |-> {phy_interrupt, bus_reset_start} == $past(d10, 4))
    else $error("second flag pair wrong");
  a_reg_complete: assert property (reg_valid == $past(s7, 4))
    else $error("register result without eight status cycles");
  a_reg_fields: assert property (
    reg_valid |-> {reg_data, reg_addr} == $past(sh_reg, 3))
    else $error("register address or data wrong");
  a_rx_entry: assert property (
    $past(rc, 4) && !$past(rc, 5) |-> rx_active && fair_request_lost)
    else $error("receive entry not flagged");
  a_speed_decode: assert property (
    rx_speed_valid |-> $past(rc, 4) && $past(d7, 5) && rx_speed == rate_of($past(phy_data, 4)))
    else $error("speed code decode wrong");
  a_rx_end: assert property ($past(id, 4) && $past(rc, 5) |-> rx_packet_end)
    else $error("receive end not flagged");
  a_null_end: assert property (
    rx_null_packet |-> rx_packet_end && $past(d7, 5))
    else $error("null packet flag wrong");
  cover property (reg_valid);
  cover property (rx_null_packet);
  cover property (rx_speed_valid ##[1:20] rx_packet_end);
endmodule
bind phy_link_status_receive phy_rx_chk chk_u (.clk, .reset_n, .interface_control_lines,
  .phy_data, .arb_reset_gap, .subaction_gap, .bus_reset_start, .phy_interrupt, .reg_valid,
  .reg_addr, .reg_data, .rx_active, .rx_speed_valid, .rx_speed, .rx_null_packet,
  .rx_packet_end, .fair_request_lost);

// file: testbench/phy_model.sv
// behavioural phy driving control and data lines toward the link
`timescale 1ns/1ps
module phy_model (
  // clock
  input wire logic clk,
  // lines toward the link
  output logic [1:0] ctl,
  output logic [7:0] dat
);
  logic [7:0] pkt [$];
  initial begin
    ctl = phy_rx_pkg::CTL_IDLE;
    dat = 8'h00;
  end
  // one cycle on the lines, changed just after the edge
  task cyc(input logic [1:0] c, input logic [7:0] d);
    @(posedge clk);
    ctl <= c;
    dat <= d;
  endtask
  // idle cycles; unused data lines keep toggling
  task idle(input int n);
    repeat (n) cyc(phy_rx_pkg::CTL_IDLE, ~dat);
  endtask
  // status cycles, bit 2k on line 0 and 2k+1 on line 1
  task status(input int n, input logic [15:0] b);
    for (int k = 0; k < n; k++) begin
      cyc(phy_rx_pkg::CTL_STATUS, {~dat[7:2], b[2*k+1], b[2*k]});
    end
  endtask
  // data-on, then speed code and queued bytes unless null, then idle
  task receive(input int on_n, input logic [7:0] spd, input logic nul);
    repeat (on_n) cyc(phy_rx_pkg::CTL_RECEIVE, phy_rx_pkg::DATA_ON_CODE);
    if (!nul) begin
      cyc(phy_rx_pkg::CTL_RECEIVE, spd);
      while (pkt.size() > 0) cyc(phy_rx_pkg::CTL_RECEIVE, pkt.pop_front());
    end
    idle(1);
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the phy status and receive decoder
`timescale 1ns/1ps
module tb_top;
  logic clk, reset_n, pkt_ready = 1'b0, stall, pkt_valid, reg_valid, rx_overflow, rx_null_packet;
  logic rx_speed_valid, rx_packet_end;
  logic [1:0] ctl, max_rate, rx_speed;
  wire logic [3:0] flags;
  logic [1:0] spd_rate [4] = '{phy_rx_pkg::RATE_S100, phy_rx_pkg::RATE_S200,
    phy_rx_pkg::RATE_S400, phy_rx_pkg::RATE_BAD};
  logic [15:0] spd_q [$];
  int n_flag [4] = '{0, 0, 0, 0};
  int exp_flag [4] = '{0, 0, 0, 0};
  int n_end = 0;
  logic [7:0] dat, pkt_data, reg_data;
  logic [3:0] reg_addr;
  logic [31:0] seed = 32'h92D1;
  logic [31:0] rs = 32'h92D1;
  logic [7:0] spd [4] = '{8'h15, 8'h4A, 8'h50, 8'h60};
  logic [15:0] byte_q [$];
  logic [15:0] reg_q [$];
  int n_mismatch = 0;
  int n_tests = 0;
  int n_ovf = 0;
  int n_null = 0;
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  phy_model phy_u (.clk(clk), .ctl(ctl), .dat(dat));
  phy_link_status_receive dut_u (.clk(clk), .reset_n(reset_n), .interface_control_lines(ctl),
    .phy_data(dat), .max_rate(max_rate), .arb_reset_gap(flags[0]), .subaction_gap(flags[1]),
    .bus_reset_start(flags[2]), .phy_interrupt(flags[3]), .reg_valid(reg_valid),
    .reg_addr(reg_addr), .reg_data(reg_data), .rx_active(), .rx_speed_valid(rx_speed_valid),
    .rx_speed(rx_speed), .rx_null_packet(rx_null_packet), .rx_packet_end(rx_packet_end),
    .rx_overflow(rx_overflow),
    .fair_request_lost(), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_data(pkt_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // expected flag pulses of the first two status cycles
  task note_flags(input logic [3:0] f);
    for (int i = 0; i < 4; i++) begin
      exp_flag[i] += f[i];
    end
  endtask
  task give_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // random stalls of the far side; results matched against the oldest note
  always @(posedge clk) begin
    rs <= lfsr(rs);
    pkt_ready <= !stall && rs[3];
    if (pkt_valid && pkt_ready) check("pkt_data", byte_q.size() ? byte_q.pop_front() : 16'hXXXX,
      {8'h00, pkt_data});
    if (reg_valid) check("reg", reg_q.size() ? reg_q.pop_front() : 16'hXXXX,
      {4'h0, reg_data, reg_addr});
    if (rx_speed_valid) check("rx_speed", spd_q.size() ? spd_q.pop_front() : 16'hXXXX,
      {14'h0, rx_speed});
    if (rx_overflow) n_ovf++;
    if (rx_null_packet) n_null++;
    if (rx_packet_end) n_end++;
    for (int i = 0; i < 4; i++) begin
      if (flags[i]) n_flag[i]++;
    end
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    max_rate = phy_rx_pkg::RATE_S400;
    stall = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    phy_u.idle(2);
    // flag-only and full status transfers
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      note_flags(seed[3:0]);
      phy_u.status(2, seed[15:0]);
      phy_u.idle(1);
      note_flags(seed[19:16]);
      reg_q.push_back({4'h0, seed[31:20]});
      phy_u.status(8, seed[31:16]);
      phy_u.idle(1);
    end
    // status cut by a null receive, then retried in full
    note_flags(seed[3:0]);
    phy_u.status(5, seed[15:0]);
    phy_u.receive(1, 8'h00, 1'b1);
    note_flags(seed[3:0]);
    reg_q.push_back({4'h0, seed[15:4]});
    phy_u.status(8, seed[15:0]);
    phy_u.idle(1);
    // every speed code against every supported rate
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 4; c++) begin
        max_rate <= r[1:0];
        seed = lfsr(seed);
        for (int i = 0; i < 3; i++) begin
          phy_u.pkt.push_back(seed[8*i +: 8]);
          if (c <= r) byte_q.push_back({8'h00, seed[8*i +: 8]});
        end
        spd_q.push_back({14'h0, spd_rate[c]});
        phy_u.receive(1 + c % 2, spd[c], 1'b0);
        phy_u.idle(2);
      end
    end
    // far side stalls while a long packet overruns the fifo
    phy_u.idle(10);
    stall <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      phy_u.pkt.push_back(seed[7:0] + i[7:0]);
      if (i < 8) byte_q.push_back({8'h00, seed[7:0] + i[7:0]});
    end
    spd_q.push_back({14'h0, phy_rx_pkg::RATE_S400});
    phy_u.receive(2, 8'h50, 1'b0);
    phy_u.idle(8);
    stall <= 1'b0;
    phy_u.idle(40);
    check("overflow count", 16'h0004, n_ovf[15:0]);
    check("null count", 16'h0001, n_null[15:0]);
    check("end count", 16'h000E, n_end[15:0]);
    for (int i = 0; i < 4; i++) begin
      check("flag count", 16'(exp_flag[i]), 16'(n_flag[i]));
    end
    check("speed notes left", 16'h0000, 16'(spd_q.size()));
    check("notes left", 16'h0000, 16'(byte_q.size() + reg_q.size()));
    give_verdict();
  end
endmodule
